// ### rtl/scc_pkg.sv
// Package with the register map, field positions and encodings of the system control block.
package scc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] AIRC_OFS = 8'h0C;
  localparam logic [7:0] SLEEP_OFS = 8'h10;
  localparam logic [7:0] CFG_OFS = 8'h14;

  // ----------------------------------------------------------------------
  // Interrupt and reset control fields
  // ----------------------------------------------------------------------
  localparam logic [15:0] WRITE_KEY = 16'h05FA;
  localparam logic [15:0] READ_KEY = 16'hFA05;
  localparam int KEY_LSB = 16;
  localparam int ENDIAN_BIT = 15;
  localparam int PRIGRP_LSB = 8;
  localparam int SYSRST_BIT = 2;
  localparam logic [2:0] PRIGRP_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Sleep control fields
  // ----------------------------------------------------------------------
  localparam int EVPEND_BIT = 4;
  localparam int DEEP_BIT = 2;
  localparam int SLEXIT_BIT = 1;

  // ----------------------------------------------------------------------
  // Configuration control fields
  // ----------------------------------------------------------------------
  localparam int STKAL_BIT = 9;
  localparam int BFIGN_BIT = 8;
  localparam int DIVZ_BIT = 4;
  localparam int UNAL_BIT = 3;
  localparam int TRIG_BIT = 1;
  localparam int THRD_BIT = 0;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

endpackage : scc_pkg

// ### rtl/scc_pri_if.sv
// Interface carrying a priority pair and its group comparison result.
interface scc_pri_if;
  logic [2:0] grouping;
  logic [7:0] pri_new;
  logic [7:0] pri_cur;
  logic preempt;
  modport cmp (input grouping, input pri_new, input pri_cur, output preempt);
  modport user (output grouping, output pri_new, output pri_cur, input preempt);
endinterface : scc_pri_if

// ### rtl/scc_group_cmp.sv
// Group priority comparator that masks subpriority bits by the grouping code.
module scc_group_cmp (
  scc_pri_if.cmp p
);

  logic [7:0] mask;

  // Code n leaves bits [7:n+1] as group priority; code 7 leaves none.
  always_comb begin
    mask = 8'hFF << (p.grouping + 3'h1);
    if (p.grouping == 3'h7) begin
      mask = 8'h00;
    end
  end

  // [R4] group only compare
  // Lower value is more urgent, so a strictly smaller group preempts.
  assign p.preempt = (p.pri_new & mask) < (p.pri_cur & mask);

endmodule : scc_group_cmp

// ### rtl/scc_regs.sv
// System control configuration registers with their core-side control outputs.
// What this block does
// [R1] Writes to interrupt/reset control need key 0x5FA; key reads 0xFA05.
// [R2] Three-bit grouping field places a binary point in 8-bit priorities.
// [R3] Each grouping code gives fixed group/subpriority split, 0b011 gives 16/16.
// [R4] Preemption compares only the group priority part.
// [R5] Writing 1 to reset request pulses outer reset request; bit reads 0.
// [R6] Software writes 0 to both debug bits; they read as 0.
// [R7] Event-on-pending set: any interrupt wakes; clear: only enabled ones.
// [R8] Send-event instruction or external event always wakes the core.
// [R9] Deep-sleep bit selects ordinary sleep (0) or deep sleep (1).
// [R10] Sleep-on-exit bit makes handler-to-thread return enter sleep.
// [R11] Stack alignment bit selects 4 or 8 byte alignment, recorded in bit 9.
// [R12] Bus-fault-ignore clear: data bus fault at priority -1/-2 locks up.
// [R13] Bus-fault-ignore set: such handlers ignore data bus faults and continue.
// [R14] Software sets bus-fault-ignore only with handler and data in safe memory.
// [R15] Divide trap set: zero divisor faults; clear: quotient is zero.
// [R16] Unaligned trap set: unaligned halfword or word access faults.
// [R17] Unaligned multiple and doubleword transfers always fault.
// [R18] Unprivileged trigger bit permits unprivileged trigger register access.
// [R19] Thread-entry bit 0 allows thread entry only with no active exception.
// [R20] Reserved bits read zero and ignore writes.
// [R21] Endianness status bit is read-only: 0 little, 1 big.
module scc_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic big_endian,
  input wire logic [7:0] pri_new,
  input wire logic [7:0] pri_cur,
  output logic preempt,
  input wire logic irq_pending_any,
  input wire logic irq_pending_enabled,
  input wire logic event_enabled,
  input wire logic sev_exec,
  input wire logic ext_event,
  output logic wake,
  input wire logic sleep_req,
  input wire logic handler_return,
  output logic sleep_enter,
  output logic deep_sleep_enter,
  output logic sys_reset_req,
  output logic stack_align8,
  input wire logic bus_fault_in,
  input wire logic in_neg_priority,
  output logic lockup,
  output logic bus_fault_ignored,
  input wire logic div_zero,
  output logic div_trap,
  input wire logic unaligned_single,
  input wire logic unaligned_multi,
  output logic usage_fault,
  input wire logic unpriv_trig_access,
  output logic trig_access_ok,
  input wire logic exc_active,
  input wire logic exc_return_thread,
  output logic thread_entry_ok,
  output logic [2:0] priority_grouping
);

  // ----------------------------------------------------------------------
  // Stored fields
  // ----------------------------------------------------------------------
  logic [2:0] priority_grouping_field_r;
  logic event_on_pending_bit_r;
  logic deep_sleep_select_bit_r;
  logic sleep_on_handler_return_bit_r;
  logic stack_alignment_bit_r;
  logic bus_fault_ignore_bit_r;
  logic divide_zero_trap_bit_r;
  logic unaligned_trap_bit_r;
  logic unprivileged_trigger_access_bit_r;
  logic thread_entry_any_level_bit_r;
  logic [31:0] airc_rd;
  logic [31:0] sleep_rd;
  logic [31:0] cfg_rd;
  logic preempt_nxt;
  logic key_ok;
  logic sleep_any;
  logic wake_nxt;
  logic deep_nxt;
  logic lockup_nxt;
  logic ignored_nxt;
  logic div_trap_nxt;
  logic usage_fault_nxt;
  logic trig_ok_nxt;
  logic thread_ok_nxt;

  scc_pri_if pri_bus ();

  assign pri_bus.grouping = priority_grouping_field_r;
  assign pri_bus.pri_new = pri_new;
  assign pri_bus.pri_cur = pri_cur;
  assign preempt_nxt = pri_bus.preempt;

  // [R4] group comparator
  scc_group_cmp u_cmp (
    .p(pri_bus.cmp)
  );

  // [R1] key check
  // Only the upper half of the data carries the key.
  assign key_ok = (wdata[31:scc_pkg::KEY_LSB] == scc_pkg::WRITE_KEY);

  // ----------------------------------------------------------------------
  // Interrupt and reset control register
  // ----------------------------------------------------------------------

  // [R2] grouping field store
  // [R3] codes kept verbatim
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      priority_grouping_field_r <= scc_pkg::PRIGRP_RST;
    end else if (wr_en && addr == scc_pkg::AIRC_OFS && key_ok) begin
      priority_grouping_field_r <= wdata[scc_pkg::PRIGRP_LSB +: 3];
    end
  end

  // [R5] reset request pulse
  // A single-cycle pulse; the outer reset controller stretches it as needed.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= wr_en && addr == scc_pkg::AIRC_OFS && key_ok &&
                       wdata[scc_pkg::SYSRST_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Sleep control register
  // ----------------------------------------------------------------------

  // [R20] only named bits stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_on_pending_bit_r <= 1'b0;
      deep_sleep_select_bit_r <= 1'b0;
      sleep_on_handler_return_bit_r <= 1'b0;
    end else if (wr_en && addr == scc_pkg::SLEEP_OFS) begin
      event_on_pending_bit_r <= wdata[scc_pkg::EVPEND_BIT];
      deep_sleep_select_bit_r <= wdata[scc_pkg::DEEP_BIT];
      sleep_on_handler_return_bit_r <= wdata[scc_pkg::SLEXIT_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Configuration control register
  // ----------------------------------------------------------------------

  // [R20] only named bits stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_alignment_bit_r <= 1'b0;
      bus_fault_ignore_bit_r <= 1'b0;
      divide_zero_trap_bit_r <= 1'b0;
      unaligned_trap_bit_r <= 1'b0;
      unprivileged_trigger_access_bit_r <= 1'b0;
      thread_entry_any_level_bit_r <= 1'b0;
    end else if (wr_en && addr == scc_pkg::CFG_OFS) begin
      stack_alignment_bit_r <= wdata[scc_pkg::STKAL_BIT];
      bus_fault_ignore_bit_r <= wdata[scc_pkg::BFIGN_BIT];
      divide_zero_trap_bit_r <= wdata[scc_pkg::DIVZ_BIT];
      unaligned_trap_bit_r <= wdata[scc_pkg::UNAL_BIT];
      unprivileged_trigger_access_bit_r <= wdata[scc_pkg::TRIG_BIT];
      thread_entry_any_level_bit_r <= wdata[scc_pkg::THRD_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  // [R1] key readback
  // [R6] debug bits read zero
  // [R21] endianness status
  always_comb begin
    airc_rd = scc_pkg::REG_RST;
    airc_rd[31:scc_pkg::KEY_LSB] = scc_pkg::READ_KEY;
    airc_rd[scc_pkg::ENDIAN_BIT] = big_endian;
    airc_rd[scc_pkg::PRIGRP_LSB +: 3] = priority_grouping_field_r;
  end

  // [R20] reserved reads zero
  always_comb begin
    sleep_rd = scc_pkg::REG_RST;
    sleep_rd[scc_pkg::EVPEND_BIT] = event_on_pending_bit_r;
    sleep_rd[scc_pkg::DEEP_BIT] = deep_sleep_select_bit_r;
    sleep_rd[scc_pkg::SLEXIT_BIT] = sleep_on_handler_return_bit_r;
    cfg_rd = scc_pkg::REG_RST;
    cfg_rd[scc_pkg::STKAL_BIT] = stack_alignment_bit_r;
    cfg_rd[scc_pkg::BFIGN_BIT] = bus_fault_ignore_bit_r;
    cfg_rd[scc_pkg::DIVZ_BIT] = divide_zero_trap_bit_r;
    cfg_rd[scc_pkg::UNAL_BIT] = unaligned_trap_bit_r;
    cfg_rd[scc_pkg::TRIG_BIT] = unprivileged_trigger_access_bit_r;
    cfg_rd[scc_pkg::THRD_BIT] = thread_entry_any_level_bit_r;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= scc_pkg::REG_RST;
    end else if (rd_en) begin
      case (addr)
        scc_pkg::AIRC_OFS: rdata <= airc_rd;
        scc_pkg::SLEEP_OFS: rdata <= sleep_rd;
        scc_pkg::CFG_OFS: rdata <= cfg_rd;
        default: rdata <= scc_pkg::REG_RST;
      endcase
    end else begin
      rdata <= scc_pkg::REG_RST;
    end
  end

  // ----------------------------------------------------------------------
  // Core-side decisions, registered one cycle after their inputs; stack_align8 and priority_grouping two cycles after the write
  // ----------------------------------------------------------------------

  // Next values of the wake, sleep, fault, trap and permission outputs, from this cycle's inputs and stored bits.
  // Gathering them here keeps each output below a plain flip-flop copy, free of glitches.
  always_comb begin
    // [R7] wake source select
    // [R8] event always wakes
    wake_nxt = (event_on_pending_bit_r ? irq_pending_any : irq_pending_enabled) ||
               event_enabled || sev_exec || ext_event;
    // [R10] sleep on return
    sleep_any = sleep_req || (handler_return && sleep_on_handler_return_bit_r);
    // [R9] sleep depth select
    deep_nxt = sleep_any && deep_sleep_select_bit_r;
    // [R12] lockup on fault
    lockup_nxt = bus_fault_in && in_neg_priority && !bus_fault_ignore_bit_r;
    // [R13] ignore when enabled
    ignored_nxt = bus_fault_in && in_neg_priority && bus_fault_ignore_bit_r;
    // [R15] divide trap
    div_trap_nxt = div_zero && divide_zero_trap_bit_r;
    // [R16] unaligned single trap
    // [R17] multiple always faults
    usage_fault_nxt = unaligned_multi || (unaligned_single && unaligned_trap_bit_r);
    // [R18] trigger access gate
    trig_ok_nxt = unpriv_trig_access && unprivileged_trigger_access_bit_r;
    // [R19] thread entry gate
    thread_ok_nxt = !exc_active || (thread_entry_any_level_bit_r && exc_return_thread);
  end

  // Wake request towards the core.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake <= 1'b0;
    end else begin
      wake <= wake_nxt;
    end
  end

  // Sleep entry and its depth; deep sleep is only ever flagged beside sleep entry.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_enter <= 1'b0;
      deep_sleep_enter <= 1'b0;
    end else begin
      sleep_enter <= sleep_any;
      deep_sleep_enter <= deep_nxt;
    end
  end

  // Fault outcome at negative priority; the two outputs are never high together.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockup <= 1'b0;
      bus_fault_ignored <= 1'b0;
    end else begin
      lockup <= lockup_nxt;
      bus_fault_ignored <= ignored_nxt;
    end
  end

  // Divide trap towards the core.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_trap <= 1'b0;
    end else begin
      div_trap <= div_trap_nxt;
    end
  end

  // Usage fault for unaligned transfers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      usage_fault <= 1'b0;
    end else begin
      usage_fault <= usage_fault_nxt;
    end
  end

  // Permission for unprivileged access to the trigger register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_access_ok <= 1'b0;
    end else begin
      trig_access_ok <= trig_ok_nxt;
    end
  end

  // Permission to enter thread mode; held low while reset stands.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      thread_entry_ok <= 1'b0;
    end else begin
      thread_entry_ok <= thread_ok_nxt;
    end
  end

  // [R11] alignment select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_align8 <= 1'b0;
    end else begin
      stack_align8 <= stack_alignment_bit_r;
    end
  end

  // [R2] grouping to core
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      priority_grouping <= scc_pkg::PRIGRP_RST;
    end else begin
      priority_grouping <= priority_grouping_field_r;
    end
  end

  // [R4] preemption result
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      preempt <= 1'b0;
    end else begin
      preempt <= preempt_nxt;
    end
  end

endmodule : scc_regs

// ### testbench/scc_regs_properties.sv
// Checker with the concurrent properties of the system control registers.
module scc_regs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic big_endian,
  input wire logic [7:0] pri_new,
  input wire logic [7:0] pri_cur,
  input wire logic preempt,
  input wire logic sys_reset_req,
  input wire logic bus_fault_in,
  input wire logic in_neg_priority,
  input wire logic lockup,
  input wire logic bus_fault_ignored,
  input wire logic [2:0] priority_grouping
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Shadow state
  // ------
  logic [31:0] cfg_r;
  logic pre_exp;
  logic [7:0] pri_new_r;
  logic [7:0] pri_cur_r;
  // Priorities of the previous cycle, which line up with the grouping output shown now.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pri_new_r <= 8'h00;
      pri_cur_r <= 8'h00;
    end else begin
      pri_new_r <= pri_new;
      pri_cur_r <= pri_cur;
    end
  end
  // Code 7 shifts every bit out, so equal groups never preempt.
  assign pre_exp = (pri_new_r >> (priority_grouping + 4'h1)) <
    (pri_cur_r >> (priority_grouping + 4'h1));
  // Configuration word tracked from the bus alone, not from the design.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= 32'h0000_0000;
    end else if (wr_en && addr == scc_pkg::CFG_OFS) begin
      cfg_r <= wdata;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_key_wr;
    wr_en && addr == scc_pkg::AIRC_OFS && wdata[31:16] == scc_pkg::WRITE_KEY;
  endsequence
  sequence s_pulse;
    sys_reset_req ##1 !sys_reset_req;
  endsequence
  property p_key_wr; s_key_wr |=> ##1 priority_grouping == $past(wdata[10:8], 2); endproperty
  a_key_wr: assert property (p_key_wr) else $error("grouping not taken");
  property p_key_ign; wr_en && addr == scc_pkg::AIRC_OFS &&
    wdata[31:16] != scc_pkg::WRITE_KEY |=> ##1 $stable(priority_grouping); endproperty
  a_key_ign: assert property (p_key_ign) else $error("keyless write taken");
  property p_airc_rd; rd_en && addr == scc_pkg::AIRC_OFS |=> rdata ==
    {scc_pkg::READ_KEY, $past(big_endian), 4'h0, priority_grouping, 8'h00}; endproperty
  a_airc_rd: assert property (p_airc_rd) else $error("control read wrong");
  property p_rst; s_key_wr ##0 wdata[scc_pkg::SYSRST_BIT] |=> s_pulse; endproperty
  a_rst: assert property (p_rst) else $error("reset pulse wrong");
  property p_pre; preempt == pre_exp; endproperty
  a_pre: assert property (p_pre) else $error("preempt wrong");
  property p_lock; bus_fault_in && in_neg_priority && !cfg_r[8] |=>
    lockup && !bus_fault_ignored; endproperty
  a_lock: assert property (p_lock) else $error("no lockup");
  property p_bfign; bus_fault_in && in_neg_priority && cfg_r[8] |=>
    bus_fault_ignored && !lockup; endproperty
  a_bfign: assert property (p_bfign) else $error("fault not ignored");
  property p_cfg_rd; rd_en && addr == scc_pkg::CFG_OFS |=>
    rdata == ($past(cfg_r) & 32'h0000_031B); endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");
endmodule : scc_regs_chk

bind scc_regs scc_regs_chk u_chk (.clk, .sys_rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
  .big_endian, .pri_new, .pri_cur, .preempt, .sys_reset_req, .bus_fault_in,
  .in_neg_priority, .lockup, .bus_fault_ignored, .priority_grouping);

// ### testbench/scc_rst_model.sv
// Model of the outer reset controller that counts reset requests.
module scc_rst_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sys_reset_req,
  output logic [7:0] rst_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // counts each request
  // Every high cycle counts, so a stretched pulse shows as more than one.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt <= 8'h00;
    end else if (sys_reset_req) begin
      rst_cnt <= rst_cnt + 8'h01;
    end
  end
endmodule : scc_rst_model

// ### testbench/tb.sv
// Self-checking testbench for the system control configuration registers.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] AI = scc_pkg::AIRC_OFS;
  localparam logic [7:0] SL = scc_pkg::SLEEP_OFS;
  localparam logic [7:0] CF = scc_pkg::CFG_OFS;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  // Core-side inputs as {pri_new, pri_cur, sixteen single-bit inputs}.
  logic [31:0] ci = 32'h0000_0000;
  logic [31:0] rdata;
  wire logic [11:0] co;
  logic [2:0] pg;
  logic [7:0] rst_cnt;
  int errors = 0;
  int n_tests = 0;
  // Clock of 10 ns period.
  always #5 clk = ~clk;
  scc_regs dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .big_endian(ci[0]), .pri_new(ci[31:24]),
    .pri_cur(ci[23:16]), .preempt(co[0]), .irq_pending_any(ci[1]),
    .irq_pending_enabled(ci[2]), .event_enabled(ci[3]), .sev_exec(ci[4]),
    .ext_event(ci[5]), .wake(co[1]), .sleep_req(ci[6]), .handler_return(ci[7]),
    .sleep_enter(co[2]), .deep_sleep_enter(co[3]), .sys_reset_req(co[4]),
    .stack_align8(co[5]), .bus_fault_in(ci[8]), .in_neg_priority(ci[9]), .lockup(co[6]),
    .bus_fault_ignored(co[7]), .div_zero(ci[10]), .div_trap(co[8]),
    .unaligned_single(ci[11]), .unaligned_multi(ci[12]), .usage_fault(co[9]),
    .unpriv_trig_access(ci[13]), .trig_access_ok(co[10]), .exc_active(ci[14]),
    .exc_return_thread(ci[15]), .thread_entry_ok(co[11]), .priority_grouping(pg));
  scc_rst_model u_rst (.clk(clk), .sys_rst(sys_rst), .sys_reset_req(co[4]), .rst_cnt(rst_cnt));
  // ------
  // Bus and compare tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  // Outputs are registered, so one output is judged one cycle after the inputs.
  task automatic dc(input logic [31:0] v, input int i, input logic e);
    @(posedge clk);
    ci <= v;
    @(posedge clk);
    #1;
    chk(32'(co[i]), 32'(e));
  endtask : dc
  // ------
  // Scenarios
  // ------
  task automatic t_key;
    rd(AI, 32'hFA05_0000);
    rd(SL, 32'h0000_0000);
    rd(CF, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(AI, 32'h05FB_0500);
    rd(AI, 32'hFA05_0000);
    wr(AI, 32'h05FA_0300);
    rd(AI, 32'hFA05_0300);
    chk(32'(pg), 32'h0000_0003);
    dc(32'h0000_0001, 4, 1'b0);
    rd(AI, 32'hFA05_8300);
  endtask : t_key
  // Big-endian input is still high here, so bit 15 reads set.
  task automatic t_sysrst;
    wr(AI, 32'h05FA_0304);
    wr(AI, 32'h0000_0004);
    rd(AI, 32'hFA05_8300);
    chk(32'(rst_cnt), 32'h0000_0001);
  endtask : t_sysrst
  // Codes 0 to 6: a win by the lowest group bit preempts; under code 7, and on a subpriority win, nothing preempts.
  task automatic t_group;
    logic [8:0] g;
    for (int n = 0; n < 8; n++) begin
      g = 9'(9'h001 << (n + 1));
      wr(AI, {scc_pkg::WRITE_KEY, 5'h00, n[2:0], 8'h00});
      dc({g[7:0] - 8'h01, g[7:0], 16'h0000}, 0, n != 7);
      dc({8'h00, g[7:0] - 8'h01, 16'h0000}, 0, 1'b0);
    end
  endtask : t_group
  task automatic t_wake;
    dc(32'h0000_0002, 1, 1'b0);
    dc(32'h0000_0004, 1, 1'b1);
    dc(32'h0000_0010, 1, 1'b1);
    dc(32'h0000_0020, 1, 1'b1);
    dc(32'h0000_0008, 1, 1'b1);
    wr(SL, 32'hFFFF_FFFF);
    rd(SL, 32'h0000_0016);
    dc(32'h0000_0002, 1, 1'b1);
  endtask : t_wake
  task automatic t_sleep;
    dc(32'h0000_0080, 3, 1'b1);
    wr(SL, 32'h0000_0002);
    dc(32'h0000_0080, 2, 1'b1);
    dc(32'h0000_0080, 3, 1'b0);
    wr(SL, 32'h0000_0000);
    dc(32'h0000_0080, 2, 1'b0);
    dc(32'h0000_0040, 2, 1'b1);
  endtask : t_sleep
  // Every configuration bit set, then every bit clear.
  task automatic t_cfg;
    wr(CF, 32'hFFFF_FFFF);
    rd(CF, 32'h0000_031B);
    dc(32'h0000_0000, 5, 1'b1);
    dc(32'h0000_0300, 7, 1'b1);
    dc(32'h0000_0400, 8, 1'b1);
    dc(32'h0000_0800, 9, 1'b1);
    dc(32'h0000_2000, 10, 1'b1);
    dc(32'h0000_C000, 11, 1'b1);
    wr(CF, 32'h0000_0000);
    dc(32'h0000_0000, 5, 1'b0);
    dc(32'h0000_0300, 6, 1'b1);
    dc(32'h0000_0400, 8, 1'b0);
    dc(32'h0000_0800, 9, 1'b0);
    dc(32'h0000_1000, 9, 1'b1);
    dc(32'h0000_2000, 10, 1'b0);
    dc(32'h0000_C000, 11, 1'b0);
  endtask : t_cfg
  task automatic give_verdict;
    $display("errors %0d, n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_key;
    t_sysrst;
    t_group;
    t_wake;
    t_sleep;
    t_cfg;
    give_verdict;
  end
  // The run needs well under 1000 cycles; this only cuts a hang short.
  initial begin
    #20_000;
    errors++;
    give_verdict;
  end
endmodule : tb
